// file: hdl/ignition_regs.svh
// Constants for the ignition select and torque handshake block.
// Assumes a 25 MHz controller clock; times are given in their own unit.
`ifndef IGNITION_REGS_SVH
`define IGNITION_REGS_SVH

`define CLK_HZ 25000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define CYC_PER_US (`CLK_HZ / 1000000)

`define PERMIT_FREQ_HZ 50
`define PERMIT_HALF_CYC (`CLK_HZ / (2 * `PERMIT_FREQ_HZ))
`define REQ_TIMEOUT_MS 1500
`define REQ_TIMEOUT_CYC (`REQ_TIMEOUT_MS * `CYC_PER_MS)
`define CONFIRM_WIN_US 100
`define CONFIRM_WIN_CYC (`CONFIRM_WIN_US * `CYC_PER_US)

`define HALF_CNT_W 18
`define REQ_CNT_W 26
`define CONF_CNT_W 12
`define DELAY_W 4

`define COIL_A_BIT 0
`define COIL_B_BIT 1
`define COIL_C_BIT 2
`define COIL_NONE 3'h0
`define COIL_A 3'h1
`define COIL_B 3'h2
`define COIL_C 3'h4

`define DIAG_NONE 8'h00
`define DIAG_IGN_MISS 8'h2c
`define DIAG_LINK_FAULT 8'h3d

`endif

// file: hdl/ignition_pkg.sv
// Types shared by the ignition select block and its crank-edge timer.
// Assumes the constants header is compiled alongside.
package ignition_pkg;
  typedef enum logic [1:0] {
    SEEK_RISE = 2'b01,
    SEEK_FALL = 2'b10
  } seek_state_t;

  typedef enum logic [2:0] {
    MODE_REFUSE = 3'b001,
    MODE_EXEC = 3'b010,
    MODE_PERMIT = 3'b100
  } torque_mode_t;

  typedef logic [3:0] delay_t;
endpackage : ignition_pkg

// file: hdl/ign_timer_if.sv
// Carrier between the ignition controller and its crank-edge firing timer.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface ign_timer_if;
  logic start;
  logic [3:0] delay;
  logic edge_seen;
  logic fire;
  modport ctrl (output start, output delay, output edge_seen, input fire);
  modport timer (input start, input delay, input edge_seen, output fire);
endinterface : ign_timer_if

// file: hdl/coil_timer.sv
// Crank-edge down counter that marks the firing instant.
// Assumes start and edge_seen are single-cycle pulses on clk_in.
`timescale 1ns/1ps
module coil_timer (
  input wire logic clk_in,
  input wire logic srst_in,
  ign_timer_if.timer bus
);
  import ignition_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic busy_q;
  logic busy_d;
  wire last_edge = busy_q && bus.edge_seen && (cnt_q == 4'h1);

  // A new start always wins so a late tooth never fires a stale pair
  assign bus.fire = last_edge && !bus.start;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (bus.start) begin
      cnt_d = (bus.delay == 4'h0) ? 4'h1 : bus.delay;
      busy_d = 1'b1;
    end else if (busy_q && bus.edge_seen) begin
      cnt_d = cnt_q - 4'h1;
      busy_d = (cnt_q != 4'h1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  property p_fire_on_edge;
    @(posedge clk_in) disable iff (srst_in)
    bus.fire |=> !busy_q;
  endproperty
  a_fire_on_edge: assert property (p_fire_on_edge) else $error("timer still armed after firing");
endmodule : coil_timer

// file: hdl/ignition_select_torque_handshake.sv
// Cylinder pair selection, coil drive and torque-reduction handshake.
// Assumes crank, TDC and link request inputs arrive asynchronously and are resynchronised here.
`timescale 1ns/1ps
`include "ignition_regs.svh"

module ignition_select_torque_handshake #(
  parameter int unsigned PERMIT_HALF_CYC = `PERMIT_HALF_CYC,
  parameter int unsigned REQ_TIMEOUT_CYC = `REQ_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic crank_in,
  input wire logic tdc_in,
  input wire logic ign_confirm_in,
  input wire logic engine_running_in,
  input wire logic torque_req_n_in,
  input wire logic coolant_cold_in,
  input wire logic [1:0] rpm_band_in,
  input wire logic [1:0] load_band_in,
  output logic coil_a_out,
  output logic coil_b_out,
  output logic coil_c_out,
  output ignition_pkg::delay_t spark_delay_out,
  output logic torque_status_out,
  output ignition_pkg::torque_mode_t torque_mode_out,
  output logic ign_miss_fault_out,
  output logic link_fault_out,
  output logic [7:0] diag_code_out
);
  import ignition_pkg::*;

  localparam int unsigned CONFIRM_CYC = `CONFIRM_WIN_CYC;

  // Crank edges to wait after pair detection; shift entries fire later
  localparam logic [3:0] NORMAL_TBL [0:15] = '{
    4'h3, 4'h3, 4'h2, 4'h2,
    4'h2, 4'h2, 4'h2, 4'h1,
    4'h2, 4'h1, 4'h1, 4'h1,
    4'h1, 4'h1, 4'h1, 4'h1
  };
  localparam logic [3:0] SHIFT_TBL [0:15] = '{
    4'h7, 4'h8, 4'h8, 4'h9,
    4'h6, 4'h7, 4'h8, 4'h9,
    4'h6, 4'h7, 4'h7, 4'h8,
    4'h5, 4'h6, 4'h7, 4'h8
  };

  function automatic logic [3:0] tbl_index(input logic [1:0] rpm, input logic [1:0] load);
    tbl_index = {rpm, load};
  endfunction : tbl_index

  function automatic delay_t pick_delay(input logic shift, input logic [3:0] idx);
    pick_delay = shift ? SHIFT_TBL[idx] : NORMAL_TBL[idx];
  endfunction : pick_delay

  // Synchronisers; the first stage feeds only the second
  logic crank_s1_q, crank_s2_q, crank_s3_q;
  logic tdc_s1_q, tdc_s2_q;
  logic req_s1_q, req_s2_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      crank_s1_q <= 1'b0;
      crank_s2_q <= 1'b0;
      crank_s3_q <= 1'b0;
      tdc_s1_q <= 1'b0;
      tdc_s2_q <= 1'b0;
      req_s1_q <= 1'b1;
      req_s2_q <= 1'b1;
    end else begin
      crank_s1_q <= crank_in;
      crank_s2_q <= crank_s1_q;
      crank_s3_q <= crank_s2_q;
      tdc_s1_q <= tdc_in;
      tdc_s2_q <= tdc_s1_q;
      req_s1_q <= torque_req_n_in;
      req_s2_q <= req_s1_q;
    end
  end

  wire crank_rise = crank_s2_q && !crank_s3_q;
  wire crank_fall = !crank_s2_q && crank_s3_q;
  wire req_active = !req_s2_q;

  // Cylinder pair identification
  seek_state_t seek_q;
  seek_state_t seek_d;
  wire pick_b = crank_rise && tdc_s2_q;
  wire fall_check = crank_fall && (seek_q == SEEK_FALL);
  wire pick_c = fall_check && tdc_s2_q;
  wire pick_a = fall_check && !tdc_s2_q;
  wire ident = pick_a || pick_b || pick_c;
  wire [2:0] coil_sel = {pick_c, pick_b, pick_a};

  always_comb begin
    seek_d = seek_q;
    case (seek_q)
      SEEK_RISE: begin
        if (crank_rise && !tdc_s2_q) begin
          seek_d = SEEK_FALL;
        end
      end
      SEEK_FALL: begin
        if (crank_rise && tdc_s2_q) begin
          seek_d = SEEK_RISE;
        end else if (crank_fall) begin
          seek_d = SEEK_RISE;
        end
      end
      default: begin
        seek_d = SEEK_RISE;
      end
    endcase
  end

  // Torque handshake mode
  logic link_fault_q;
  torque_mode_t mode_q;
  torque_mode_t mode_d;
  wire refuse = coolant_cold_in || link_fault_q;

  always_comb begin
    if (refuse) begin
      mode_d = MODE_REFUSE;
    end else if (req_active) begin
      mode_d = MODE_EXEC;
    end else begin
      mode_d = MODE_PERMIT;
    end
  end

  // Spark timing source follows the registered mode
  wire shift_sel = (mode_q == MODE_EXEC);
  wire [3:0] spark_idx = tbl_index(rpm_band_in, load_band_in);
  wire [3:0] shift_delay = pick_delay(1'b1, tbl_index(rpm_band_in, load_band_in));
  delay_t delay_now;
  assign delay_now = pick_delay(shift_sel, spark_idx);

  ign_timer_if tif ();
  assign tif.start = ident;
  assign tif.delay = delay_now;
  assign tif.edge_seen = crank_rise || crank_fall;

  coil_timer u_timer (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .bus(tif.timer)
  );

  // Coil drive: a fresh pair starts charging and overrides any pending fire
  logic [2:0] coil_q;
  logic [2:0] coil_d;
  delay_t delay_q;
  always_comb begin
    coil_d = coil_q;
    if (ident) begin
      coil_d = coil_sel;
    end else if (tif.fire) begin
      coil_d = `COIL_NONE;
    end
  end

  // Permit pattern: equal halves of the 50 Hz period
  logic [`HALF_CNT_W-1:0] half_cnt_q;
  logic toggle_q;
  wire half_tick = (half_cnt_q == `HALF_CNT_W'(PERMIT_HALF_CYC - 1));
  wire toggle_d = half_tick ? !toggle_q : toggle_q;
  logic status_q;
  logic status_d;
  always_comb begin
    case (mode_d)
      MODE_REFUSE: status_d = 1'b0;
      MODE_EXEC: status_d = 1'b1;
      MODE_PERMIT: status_d = toggle_d;
      default: status_d = 1'b0;
    endcase
  end

  // Request timeout, counted only while the request stays low
  logic [`REQ_CNT_W-1:0] req_cnt_q;
  wire req_timeout = req_active && (req_cnt_q == `REQ_CNT_W'(REQ_TIMEOUT_CYC - 1));

  // Confirmation window after each firing
  logic conf_arm_q;
  logic [`CONF_CNT_W-1:0] conf_cnt_q;
  logic ign_miss_q;
  wire conf_expire = conf_arm_q && (conf_cnt_q == `CONF_CNT_W'(0)) && !ign_confirm_in;
  wire miss_set = conf_expire && engine_running_in;
  logic [7:0] diag_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      seek_q <= SEEK_RISE;
      coil_q <= `COIL_NONE;
      delay_q <= 4'h0;
      mode_q <= MODE_REFUSE;
      status_q <= 1'b0;
      half_cnt_q <= '0;
      toggle_q <= 1'b0;
    end else begin
      seek_q <= seek_d;
      coil_q <= coil_d;
      delay_q <= ident ? delay_now : delay_q;
      mode_q <= mode_d;
      status_q <= status_d;
      half_cnt_q <= half_tick ? '0 : half_cnt_q + 1'b1;
      toggle_q <= toggle_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      req_cnt_q <= '0;
      link_fault_q <= 1'b0;
      conf_arm_q <= 1'b0;
      conf_cnt_q <= '0;
      ign_miss_q <= 1'b0;
      diag_q <= `DIAG_NONE;
    end else begin
      // Holds at the limit so the timeout stays flagged while the request stays low
      req_cnt_q <= !req_active ? '0 : (req_timeout ? req_cnt_q : req_cnt_q + 1'b1);
      // Faults stay latched until reset; only srst_in clears the memory
      link_fault_q <= link_fault_q || req_timeout;
      ign_miss_q <= ign_miss_q || miss_set;
      if (tif.fire) begin
        conf_arm_q <= 1'b1;
        conf_cnt_q <= `CONF_CNT_W'(CONFIRM_CYC - 1);
      end else if (ign_confirm_in || conf_expire) begin
        conf_arm_q <= 1'b0;
      end else if (conf_arm_q) begin
        conf_cnt_q <= conf_cnt_q - 1'b1;
      end
      if (req_timeout && !link_fault_q) begin
        diag_q <= `DIAG_LINK_FAULT;
      end else if (miss_set && !ign_miss_q) begin
        diag_q <= `DIAG_IGN_MISS;
      end
    end
  end

  assign coil_a_out = coil_q[`COIL_A_BIT];
  assign coil_b_out = coil_q[`COIL_B_BIT];
  assign coil_c_out = coil_q[`COIL_C_BIT];
  assign spark_delay_out = delay_q;
  assign torque_status_out = status_q;
  assign torque_mode_out = mode_q;
  assign ign_miss_fault_out = ign_miss_q;
  assign link_fault_out = link_fault_q;
  assign diag_code_out = diag_q;

  property p_pick_b;
    @(posedge clk_in) disable iff (srst_in)
    (crank_rise && tdc_s2_q) |=> (coil_q == `COIL_B);
  endproperty
  a_pick_b: assert property (p_pick_b) else $error("driver B not charged on TDC high rise");

  property p_pick_c;
    @(posedge clk_in) disable iff (srst_in)
    (crank_fall && seek_q == SEEK_FALL && tdc_s2_q) |=> (coil_q == `COIL_C);
  endproperty
  a_pick_c: assert property (p_pick_c) else $error("driver C not charged on low then high");

  property p_pick_a;
    @(posedge clk_in) disable iff (srst_in)
    (crank_fall && seek_q == SEEK_FALL && !tdc_s2_q) |=> (coil_q == `COIL_A);
  endproperty
  a_pick_a: assert property (p_pick_a) else $error("driver A not charged on low then low");

  property p_fire_release;
    @(posedge clk_in) disable iff (srst_in)
    (tif.fire && !ident) |=> (coil_q == `COIL_NONE);
  endproperty
  a_fire_release: assert property (p_fire_release) else $error("coil still on after firing");

  property p_shift_table;
    @(posedge clk_in) disable iff (srst_in)
    (ident && mode_q == MODE_EXEC) |=> (delay_q == $past(shift_delay));
  endproperty
  a_shift_table: assert property (p_shift_table) else $error("shift delay not taken from shift table");

  property p_exec_high;
    @(posedge clk_in) disable iff (srst_in)
    (mode_q == MODE_EXEC) |-> status_q;
  endproperty
  a_exec_high: assert property (p_exec_high) else $error("status low while executing");

  property p_cancel;
    @(posedge clk_in) disable iff (srst_in)
    $rose(req_s2_q) |=> (mode_q != MODE_EXEC);
  endproperty
  a_cancel: assert property (p_cancel) else $error("shift mode kept after cancel");

  property p_cold_refuse;
    @(posedge clk_in) disable iff (srst_in)
    coolant_cold_in |=> (!status_q && mode_q == MODE_REFUSE);
  endproperty
  a_cold_refuse: assert property (p_cold_refuse) else $error("status not low with cold coolant");

  property p_permit_toggle;
    @(posedge clk_in) disable iff (srst_in)
    (half_tick && mode_d == MODE_PERMIT) |=> (status_q == !$past(toggle_q));
  endproperty
  a_permit_toggle: assert property (p_permit_toggle) else $error("permit pattern did not toggle");

  property p_timeout;
    @(posedge clk_in) disable iff (srst_in)
    req_timeout |=> link_fault_q && diag_code_out != `DIAG_NONE ##1 (!status_q && mode_q == MODE_REFUSE);
  endproperty
  a_timeout: assert property (p_timeout) else $error("request timeout not latched as refusal");

  property p_miss;
    @(posedge clk_in) disable iff (srst_in)
    miss_set |=> ign_miss_q;
  endproperty
  a_miss: assert property (p_miss) else $error("missed ignition not latched");

  property p_sync;
    @(posedge clk_in) disable iff (srst_in)
    crank_rise |-> ($past(crank_in, 2) && !$past(crank_in, 3));
  endproperty
  a_sync: assert property (p_sync) else $error("crank edge not two stages behind pin");

  property p_excl;
    @(posedge clk_in) disable iff (srst_in)
    $onehot(mode_q);
  endproperty
  a_excl: assert property (p_excl) else $error("handshake modes overlap");

  property p_refuse_first;
    @(posedge clk_in) disable iff (srst_in)
    refuse |=> (mode_q == MODE_REFUSE);
  endproperty
  a_refuse_first: assert property (p_refuse_first) else $error("refusal did not take priority");
endmodule : ignition_select_torque_handshake

// file: hdl/README_unused.sv
// Intentionally empty.

// file: testbench/trans_partner.sv
// Transmission-side model driving the torque-reduction request line.
// Assumes the bench commands a gear change through shift_in on the controller clock.
`timescale 1ns/1ps
module trans_partner (
  input wire logic clk_in,
  input wire logic shift_in,
  output logic torque_req_n_out
);
  // Low for the whole shift, high again to cancel; idle high from the first edge
  always @(posedge clk_in) begin
    torque_req_n_out <= ~shift_in;
  end
endmodule : trans_partner

// file: testbench/ignition_select_torque_handshake_bench.sv
// Self-checking bench for pair selection, coil firing and torque handshake.
// Assumes a 25 MHz clock and shortened permit and timeout counts.
`timescale 1ns/1ps
`include "ignition_regs.svh"
module ignition_select_torque_handshake_bench;
  import ignition_pkg::*;
  localparam int unsigned HALF = 10;
  localparam int unsigned TOUT = 200;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic crank_in = 1'b0;
  logic tdc_in = 1'b0;
  logic ign_confirm_in = 1'b0;
  logic engine_running_in = 1'b0;
  logic coolant_cold_in = 1'b0;
  logic shift = 1'b0;
  logic [1:0] rpm_band_in = 2'h2;
  logic [1:0] load_band_in = 2'h1;
  logic torque_req_n_in;
  logic coil_a_out;
  logic coil_b_out;
  logic coil_c_out;
  delay_t spark_delay_out;
  logic torque_status_out;
  torque_mode_t torque_mode_out;
  logic ign_miss_fault_out;
  logic link_fault_out;
  logic [7:0] diag_code_out;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  always #20 clk_in = ~clk_in;

  ignition_select_torque_handshake #(.PERMIT_HALF_CYC(HALF), .REQ_TIMEOUT_CYC(TOUT)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .crank_in(crank_in), .tdc_in(tdc_in),
    .ign_confirm_in(ign_confirm_in), .engine_running_in(engine_running_in),
    .torque_req_n_in(torque_req_n_in), .coolant_cold_in(coolant_cold_in),
    .rpm_band_in(rpm_band_in), .load_band_in(load_band_in),
    .coil_a_out(coil_a_out), .coil_b_out(coil_b_out), .coil_c_out(coil_c_out),
    .spark_delay_out(spark_delay_out), .torque_status_out(torque_status_out),
    .torque_mode_out(torque_mode_out), .ign_miss_fault_out(ign_miss_fault_out),
    .link_fault_out(link_fault_out), .diag_code_out(diag_code_out));

  trans_partner partner (.clk_in(clk_in), .shift_in(shift), .torque_req_n_out(torque_req_n_in));

  task automatic summarize;
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Whole run needs about 8200 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_range(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("wrong value %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_range

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // Edges spaced well past the resync latency
  task automatic step(input logic lvl, input logic t);
    @(posedge clk_in);
    crank_in <= lvl;
    tdc_in <= t;
    cyc(8);
  endtask : step

  task automatic toggles(input int n, output int k);
    logic prev;
    k = 0;
    @(posedge clk_in);
    prev = torque_status_out;
    repeat (n) begin
      @(posedge clk_in);
      if (torque_status_out !== prev) k++;
      prev = torque_status_out;
    end
  endtask : toggles

  task automatic do_reset;
    @(posedge clk_in);
    srst_in <= 1'b1;
    shift <= 1'b0;
    coolant_cold_in <= 1'b0;
    cyc(20);
    chk("reset coils", 8'h00, 8'({coil_c_out, coil_b_out, coil_a_out}));
    chk("reset mode", 8'(MODE_REFUSE), 8'(torque_mode_out));
    chk("reset diag", `DIAG_NONE, diag_code_out);
    srst_in <= 1'b0;
    cyc(4);
  endtask : do_reset

  task automatic test_pair(input logic t_fall, input logic [2:0] exp);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, t_fall);
    chk("pair coil", 8'(exp), 8'({coil_c_out, coil_b_out, coil_a_out}));
  endtask : test_pair

  // Edges after the B pick: fall, low rise, low fall
  task automatic test_fire(input logic run, input logic conf, input logic [7:0] diag_exp);
    logic [2:0] lv;
    logic [2:0] tv;
    logic [7:0] d;
    int at;
    lv = 3'b010;
    tv = 3'b001;
    at = 0;
    step(1'b0, 1'b1);
    engine_running_in <= run;
    step(1'b1, 1'b1);
    chk("fire coil", 8'(`COIL_B), 8'({coil_c_out, coil_b_out, coil_a_out}));
    chk_range("normal delay", 8'h01, 8'h03, 8'(spark_delay_out));
    d = 8'(spark_delay_out);
    for (int k = 0; k < 3; k++) begin
      step(lv[k], tv[k]);
      if (coil_b_out === 1'b0 && at == 0) at = k + 1;
    end
    chk("fire edge", d, 8'(at));
    if (conf) begin
      ign_confirm_in <= 1'b1;
      @(posedge clk_in);
      ign_confirm_in <= 1'b0;
    end
    cyc(`CONFIRM_WIN_CYC + 20);
    chk("miss fault", 8'(diag_exp != 8'h00), 8'(ign_miss_fault_out));
    chk("miss diag", diag_exp, diag_code_out);
    engine_running_in <= 1'b0;
  endtask : test_fire

  task automatic test_shift;
    int k;
    toggles(40, k);
    chk("permit toggles", 8'd4, 8'(k));
    chk("permit mode", 8'(MODE_PERMIT), 8'(torque_mode_out));
    shift <= 1'b1;
    cyc(6);
    chk("exec mode", 8'(MODE_EXEC), 8'(torque_mode_out));
    toggles(20, k);
    chk("exec toggles", 8'd0, 8'(k));
    chk("exec status", 8'h01, 8'(torque_status_out));
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    chk_range("shift delay", 8'h05, 8'h09, 8'(spark_delay_out));
    step(1'b0, 1'b1);
    shift <= 1'b0;
    cyc(6);
    chk("cancel mode", 8'(MODE_PERMIT), 8'(torque_mode_out));
    step(1'b1, 1'b1);
    chk_range("cancel delay", 8'h01, 8'h03, 8'(spark_delay_out));
    step(1'b0, 1'b1);
    coolant_cold_in <= 1'b1;
    cyc(3);
    chk("cold mode", 8'(MODE_REFUSE), 8'(torque_mode_out));
    toggles(20, k);
    chk("cold toggles", 8'd0, 8'(k));
    chk("cold status", 8'h00, 8'(torque_status_out));
    shift <= 1'b1;
    cyc(6);
    chk("cold request", 8'(MODE_REFUSE), 8'(torque_mode_out));
    shift <= 1'b0;
    coolant_cold_in <= 1'b0;
    cyc(6);
  endtask : test_shift

  task automatic test_timeout;
    do_reset();
    shift <= 1'b1;
    cyc(TOUT - 20);
    chk("early link fault", 8'h00, 8'(link_fault_out));
    cyc(30);
    chk("link fault", 8'h01, 8'(link_fault_out));
    chk("link diag", `DIAG_LINK_FAULT, diag_code_out);
    chk("link status", 8'h00, 8'(torque_status_out));
    shift <= 1'b0;
    cyc(6);
    chk("link mode", 8'(MODE_REFUSE), 8'(torque_mode_out));
  endtask : test_timeout

  initial begin
    do_reset();
    test_pair(1'b1, `COIL_C);
    test_pair(1'b0, `COIL_A);
    test_fire(1'b0, 1'b0, `DIAG_NONE);
    test_fire(1'b1, 1'b1, `DIAG_NONE);
    test_fire(1'b1, 1'b0, `DIAG_IGN_MISS);
    test_shift();
    test_timeout();
    summarize();
  end
endmodule : ignition_select_torque_handshake_bench
